// ===== scfc_consts.svh
// Named constants of the sync and pin function control slice.
// Assumes it is included by bare name from the package and the design modules.
`ifndef SCFC_CONSTS_SVH
`define SCFC_CONSTS_SVH

// ----------------------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------------------
`define SCFC_ADDR_CTRL 8'h58
`define SCFC_ADDR_UNUSED 8'h59
`define SCFC_ADDR_UPDATE 8'h5A

// ----------------------------------------------------------------------------
// Field positions of the sync and pin function control register
// ----------------------------------------------------------------------------
`define SCFC_BIT_DETECT_EN 0
`define SCFC_BIT_NARROW_SEL 1
`define SCFC_BIT_SOFT_SYNC 2
`define SCFC_BIT_DIST_REF_PD 3
`define SCFC_BIT_SYNC_PD 4
`define SCFC_ROLE_LSB 5
`define SCFC_ROLE_MSB 6
`define SCFC_BIT_UPDATE 0

// ----------------------------------------------------------------------------
// Reset values and widths
// ----------------------------------------------------------------------------
`define SCFC_CTRL_W 7
`define SCFC_CTRL_RESET 7'h00
`define SCFC_NUM_OUTPUTS 5
`define SCFC_PIN_IDLE 1'h1

// ----------------------------------------------------------------------------
// Out-of-sync thresholds, in half cycles of the high-speed clock
// ----------------------------------------------------------------------------
`define SCFC_PHASE_W 4
`define SCFC_THR_NARROW 4'h1
`define SCFC_THR_WIDE 4'h2

`endif

// ===== scfc_pkg.sv
// Types shared by the sync and pin function control slice.
// Assumes scfc_consts.svh is on the include path.
`include "scfc_consts.svh"

package scfc_pkg;

  // --------------------------------------------------------------------------
  // Role of the multipurpose function pin
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    SCFC_ROLE_RESET = 2'b00,
    SCFC_ROLE_SYNC = 2'b01,
    SCFC_ROLE_TEST = 2'b10,
    SCFC_ROLE_POWER_DOWN = 2'b11
  } scfc_pin_role_t;

endpackage

// ===== scfc_detect_if.sv
// Carries detection settings to the out-of-sync detector and its flag back.
// Assumes both ends run on the same system clock.
interface scfc_detect_if;
  logic detect_en;
  logic narrow_sel;
  logic sync_pd;
  logic out_of_sync;

  modport ctrl (output detect_en, output narrow_sel, output sync_pd, input out_of_sync);
  modport det (input detect_en, input narrow_sel, input sync_pd, output out_of_sync);
endinterface

// ===== scfc_pin_filter.sv
// Three-stage synchroniser and agreement filter for an asynchronous pin.
// Assumes the pin idles high and may change at any time.
`include "scfc_consts.svh"
module scfc_pin_filter (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  // Pin
  input wire logic pin_in,
  output logic level_out
);

  logic stage1;
  logic stage2;
  logic stage3;
  logic level;
  logic next_level;

  // A change counts only once the second and third stages agree.
  always_comb begin
    next_level = level;
    if (stage2 == stage3) begin
      next_level = stage3;
    end
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      stage1 <= `SCFC_PIN_IDLE;
      stage2 <= `SCFC_PIN_IDLE;
      stage3 <= `SCFC_PIN_IDLE;
      level <= `SCFC_PIN_IDLE;
    end else begin
      stage1 <= pin_in;
      stage2 <= stage1;
      stage3 <= stage2;
      level <= next_level;
    end
  end

  assign level_out = level;

endmodule

// ===== scfc_sync_detect.sv
// Out-of-sync detector comparing the measured divider phase difference.
// Assumes phase_diff_in comes from logic on the same clock, in half cycles.
`include "scfc_consts.svh"
module scfc_sync_detect (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  // Measured phase difference
  input wire logic [`SCFC_PHASE_W-1:0] phase_diff_in,
  // Settings and flag
  scfc_detect_if.det det
);

  logic flag;
  logic next_flag;
  logic [`SCFC_PHASE_W-1:0] threshold;

  always_comb begin
    threshold = det.narrow_sel ? `SCFC_THR_NARROW : `SCFC_THR_WIDE;
    next_flag = flag;
    // The flag is frozen while detection is off or the sync logic is powered down.
    if (det.detect_en && !det.sync_pd) begin
      next_flag = (phase_diff_in >= threshold);
    end
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      flag <= 1'b0;
    end else begin
      flag <= next_flag;
    end
  end

  assign det.out_of_sync = flag;

endmodule

// ===== scfc_regs.sv
// Sync, power-down and function pin control registers with buffered update.
// Assumes the serial port front end delivers byte writes and reads on sys_clk_in.
`include "scfc_consts.svh"
// What this block does
// - Bit 0 enables sync detection, reset off.
// - Select one flags at half-cycle offset.
// - Select zero flags at one-cycle offset.
// - Soft sync bit equals pin low sync.
// - Soft sync high forces outputs static.
// - Soft sync falling edge triggers divider sync.
// - Bit 3 powers down distribution references.
// - Bit 4 powers down sync circuitry.
// - Bits 6:5 pick pin role; 10 test.
// - Update bit copies buffer to active registers.
// - Update bit clears itself after transfer.
// - Ignore-sync outputs skip chip sync.
module scfc_regs (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  // Buffered register write port from the serial front end
  input wire logic reg_wr_in,
  input wire logic [7:0] reg_waddr_in,
  input wire logic [7:0] reg_wdata_in,
  // Register read port
  input wire logic [7:0] reg_raddr_in,
  output logic [7:0] reg_rdata_out,
  // Multipurpose function pin
  input wire logic function_pin_in,
  // Per-output ignore-sync bits and measured phase difference
  input wire logic [`SCFC_NUM_OUTPUTS-1:0] ignore_sync_in,
  input wire logic [`SCFC_PHASE_W-1:0] phase_diff_in,
  // Control outputs
  output logic update_pulse_out,
  output logic dist_ref_pd_out,
  output logic sync_pd_out,
  output logic chip_reset_out,
  output logic power_down_out,
  output logic out_of_sync_out,
  output logic [`SCFC_NUM_OUTPUTS-1:0] force_static_out,
  output logic [`SCFC_NUM_OUTPUTS-1:0] sync_trigger_out
);

  // --------------------------------------------------------------------------
  // Register state
  // --------------------------------------------------------------------------
  logic [`SCFC_CTRL_W-1:0] buf_ctrl;
  logic [`SCFC_CTRL_W-1:0] next_buf_ctrl;
  logic [`SCFC_CTRL_W-1:0] ctrl;
  logic [`SCFC_CTRL_W-1:0] next_ctrl;
  logic update_pending;
  logic next_update_pending;
  logic update_pulse;
  logic next_update_pulse;
  logic [7:0] rdata;
  logic [7:0] next_rdata;

  always_comb begin
    next_buf_ctrl = buf_ctrl;
    next_ctrl = ctrl;
    next_update_pending = 1'b0;
    next_update_pulse = 1'b0;
    if (update_pending) begin
      next_ctrl = buf_ctrl;
      next_update_pulse = 1'b1;
    end
    if (reg_wr_in && reg_waddr_in == `SCFC_ADDR_CTRL) begin
      // Bit 7 is dropped on purpose.
      next_buf_ctrl = reg_wdata_in[`SCFC_CTRL_W-1:0];
    end
    // A new update request wins over the self-clear of the previous one.
    if (reg_wr_in && reg_waddr_in == `SCFC_ADDR_UPDATE && reg_wdata_in[`SCFC_BIT_UPDATE]) begin
      next_update_pending = 1'b1;
    end
  end

  // Reads return the active value; unused slots and bits read zero.
  always_comb begin
    next_rdata = 8'h00;
    if (reg_raddr_in == `SCFC_ADDR_CTRL) begin
      next_rdata = {1'b0, ctrl};
    end
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      buf_ctrl <= `SCFC_CTRL_RESET;
      ctrl <= `SCFC_CTRL_RESET;
      update_pending <= 1'b0;
      update_pulse <= 1'b0;
      rdata <= 8'h00;
    end else begin
      buf_ctrl <= next_buf_ctrl;
      ctrl <= next_ctrl;
      update_pending <= next_update_pending;
      update_pulse <= next_update_pulse;
      rdata <= next_rdata;
    end
  end

  // --------------------------------------------------------------------------
  // Field decode
  // --------------------------------------------------------------------------
  scfc_pkg::scfc_pin_role_t role;
  logic soft_sync;
  logic pin_level;

  always_comb begin
    role = scfc_pkg::scfc_pin_role_t'(ctrl[`SCFC_ROLE_MSB:`SCFC_ROLE_LSB]);
    soft_sync = ctrl[`SCFC_BIT_SOFT_SYNC];
  end

  scfc_pin_filter u_pin_filter (
    .sys_clk_in(sys_clk_in),
    .resetn_in(resetn_in),
    .pin_in(function_pin_in),
    .level_out(pin_level)
  );

  // --------------------------------------------------------------------------
  // Out-of-sync detection
  // --------------------------------------------------------------------------
  scfc_detect_if det_bus ();

  assign det_bus.detect_en = ctrl[`SCFC_BIT_DETECT_EN];
  assign det_bus.narrow_sel = ctrl[`SCFC_BIT_NARROW_SEL];
  assign det_bus.sync_pd = ctrl[`SCFC_BIT_SYNC_PD];

  scfc_sync_detect u_sync_detect (
    .sys_clk_in(sys_clk_in),
    .resetn_in(resetn_in),
    .phase_diff_in(phase_diff_in),
    .det(det_bus.det)
  );

  // --------------------------------------------------------------------------
  // Pin roles, sync hold and sync trigger
  // --------------------------------------------------------------------------
  logic sync_hold;
  logic prev_sync_hold;
  logic next_prev_sync_hold;
  logic chip_reset;
  logic next_chip_reset;
  logic power_down;
  logic next_power_down;
  logic dist_ref_pd;
  logic next_dist_ref_pd;
  logic sync_pd;
  logic next_sync_pd;
  logic [`SCFC_NUM_OUTPUTS-1:0] force_static;
  logic [`SCFC_NUM_OUTPUTS-1:0] next_force_static;
  logic [`SCFC_NUM_OUTPUTS-1:0] sync_trigger;
  logic [`SCFC_NUM_OUTPUTS-1:0] next_sync_trigger;

  always_comb begin
    next_chip_reset = 1'b0;
    next_power_down = 1'b0;
    // The soft bit is the pin in sync role with its polarity turned round.
    sync_hold = soft_sync;
    // The test code drives no role at all, so a stray setting stays harmless.
    unique case (role)
      scfc_pkg::SCFC_ROLE_RESET: begin
        next_chip_reset = !pin_level;
      end
      scfc_pkg::SCFC_ROLE_SYNC: begin
        sync_hold = soft_sync || !pin_level;
      end
      scfc_pkg::SCFC_ROLE_TEST: begin
        next_chip_reset = 1'b0;
      end
      scfc_pkg::SCFC_ROLE_POWER_DOWN: begin
        next_power_down = !pin_level;
      end
    endcase
    next_prev_sync_hold = sync_hold;
    next_dist_ref_pd = ctrl[`SCFC_BIT_DIST_REF_PD];
    next_sync_pd = ctrl[`SCFC_BIT_SYNC_PD];
  end

  // Each output steers its own hold and trigger by its ignore-sync bit.
  genvar gi;
  generate
    for (gi = 0; gi < `SCFC_NUM_OUTPUTS; gi = gi + 1) begin : g_out
      always_comb begin
        next_force_static[gi] = sync_hold && !ignore_sync_in[gi];
        next_sync_trigger[gi] = prev_sync_hold && !sync_hold && !ignore_sync_in[gi];
      end
    end
  endgenerate

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      prev_sync_hold <= 1'b0;
      chip_reset <= 1'b0;
      power_down <= 1'b0;
      dist_ref_pd <= 1'b0;
      sync_pd <= 1'b0;
      force_static <= '0;
      sync_trigger <= '0;
    end else begin
      prev_sync_hold <= next_prev_sync_hold;
      chip_reset <= next_chip_reset;
      power_down <= next_power_down;
      dist_ref_pd <= next_dist_ref_pd;
      sync_pd <= next_sync_pd;
      force_static <= next_force_static;
      sync_trigger <= next_sync_trigger;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign reg_rdata_out = rdata;
  assign update_pulse_out = update_pulse;
  assign dist_ref_pd_out = dist_ref_pd;
  assign sync_pd_out = sync_pd;
  assign chip_reset_out = chip_reset;
  assign power_down_out = power_down;
  assign out_of_sync_out = det_bus.out_of_sync;
  assign force_static_out = force_static;
  assign sync_trigger_out = sync_trigger;

endmodule

// ===== scfc_host_model.sv
// Host model that writes the control port one byte per cycle.
// Assumes the caller enters its tasks at a falling clock edge.
module scfc_host_model (
  // Clock
  input wire logic sys_clk_in,
  // Write port
  output logic reg_wr_out,
  output logic [7:0] reg_waddr_out,
  output logic [7:0] reg_wdata_out
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    reg_wr_out = 1'b0;
    reg_waddr_out = 8'h00;
    reg_wdata_out = 8'h00;
  end

  // Holds the strobe so that calls in a row give back-to-back writes.
  task automatic write(input logic [7:0] addr, input logic [7:0] data);
    reg_wr_out = 1'b1;
    reg_waddr_out = addr;
    reg_wdata_out = data;
    @(negedge sys_clk_in);
  endtask

  // Idle lines carry the inverse so that stale values are never read as valid.
  task automatic idle(input int n);
    reg_wr_out = 1'b0;
    reg_waddr_out = ~reg_waddr_out;
    reg_wdata_out = ~reg_wdata_out;
    repeat (n) @(negedge sys_clk_in);
  endtask
endmodule

// ===== scfc_regs_sva.sv
// Checker for the sync and pin function control registers.
// Assumes it is bound to scfc_regs and sees only its ports.
`include "scfc_consts.svh"
module scfc_regs_sva (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  // Inputs
  input wire logic reg_wr_in,
  input wire logic [7:0] reg_waddr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic [7:0] reg_raddr_in,
  input wire logic function_pin_in,
  input wire logic [`SCFC_NUM_OUTPUTS-1:0] ignore_sync_in,
  input wire logic [`SCFC_PHASE_W-1:0] phase_diff_in,
  // Outputs
  input wire logic [7:0] reg_rdata_out,
  input wire logic update_pulse_out,
  input wire logic dist_ref_pd_out,
  input wire logic sync_pd_out,
  input wire logic chip_reset_out,
  input wire logic power_down_out,
  input wire logic out_of_sync_out,
  input wire logic [`SCFC_NUM_OUTPUTS-1:0] force_static_out,
  input wire logic [`SCFC_NUM_OUTPUTS-1:0] sync_trigger_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!resetn_in);
  logic upd_req;
  assign upd_req = reg_wr_in && reg_waddr_in == `SCFC_ADDR_UPDATE && reg_wdata_in[0];

  // The write is taken at one edge, arms the update, and the copy lands one edge later.
  a_update_pulse_follows: assert property (upd_req |-> ##2 update_pulse_out)
    else $error("update pulse missing after update write");
  a_update_pulse_cause: assert property (update_pulse_out |-> $past(upd_req, 2))
    else $error("update pulse without update write");
  a_dist_pd_timing: assert property (
    $changed(dist_ref_pd_out) |-> $past(update_pulse_out))
    else $error("reference power-down changed outside an update");
  a_sync_pd_timing: assert property (
    $changed(sync_pd_out) |-> $past(update_pulse_out))
    else $error("sync power-down changed outside an update");
  a_read_other_zero: assert property (
    reg_raddr_in != `SCFC_ADDR_CTRL |=> reg_rdata_out == 8'h00)
    else $error("unused address read nonzero");
  a_read_top_zero: assert property (
    reg_raddr_in == `SCFC_ADDR_CTRL |=> !reg_rdata_out[7])
    else $error("unused control bit read nonzero");
  a_ignore_masks_static: assert property (
    (force_static_out & $past(ignore_sync_in)) == 0)
    else $error("ignored output forced static");
  a_ignore_masks_trig: assert property (
    (sync_trigger_out & $past(ignore_sync_in)) == 0)
    else $error("ignored output got sync trigger");
  a_trigger_one_cycle: assert property (
    sync_trigger_out != 0 |=> sync_trigger_out == 0)
    else $error("sync trigger longer than one cycle");
  a_flag_frozen_pd: assert property (
    sync_pd_out && $past(sync_pd_out) |-> $stable(out_of_sync_out))
    else $error("flag moved while sync circuit powered down");
  a_role_exclusive: assert property (!(chip_reset_out && power_down_out))
    else $error("reset and power-down roles both active");

  c_update: cover property (update_pulse_out);
  c_trigger: cover property (sync_trigger_out != 0);
  c_flag: cover property ($rose(out_of_sync_out));
endmodule

bind scfc_regs scfc_regs_sva u_sva (.*);

// ===== scfc_tb.sv
// Self-checking bench for the sync and pin function control registers.
// Assumes the design, its checker and the host model are compiled first.
`include "scfc_consts.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk_in, resetn_in, pin, reg_wr, upd, dist_pd, sync_pd, chip_rst, pwr_dn, oos, exp_oos;
  logic [7:0] waddr, wdata, raddr, rdata;
  logic [4:0] ign, force_st, trig, trig_acc;
  logic [3:0] phase;
  logic [6:0] v, prev;
  logic acc_clr;
  int fails, n_tests, seed, n_exp, i;
  int n_upd = 0;

  scfc_regs u_dut (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .reg_wr_in(reg_wr),
    .reg_waddr_in(waddr), .reg_wdata_in(wdata), .reg_raddr_in(raddr), .reg_rdata_out(rdata),
    .function_pin_in(pin), .ignore_sync_in(ign), .phase_diff_in(phase),
    .update_pulse_out(upd), .dist_ref_pd_out(dist_pd), .sync_pd_out(sync_pd),
    .chip_reset_out(chip_rst), .power_down_out(pwr_dn), .out_of_sync_out(oos),
    .force_static_out(force_st), .sync_trigger_out(trig));
  scfc_host_model u_host (.sys_clk_in(sys_clk_in), .reg_wr_out(reg_wr),
    .reg_waddr_out(waddr), .reg_wdata_out(wdata));

  initial begin
    sys_clk_in = 1'b0;
    forever #5 sys_clk_in = ~sys_clk_in;
  end

  always @(posedge sys_clk_in) begin
    if (upd === 1'b1) n_upd++;
    // Only this process writes the accumulator; the stimulus asks for a clear.
    if (!resetn_in || acc_clr) trig_acc <= 5'h00;
    else trig_acc <= trig_acc | trig;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    raddr = a;
    @(negedge sys_clk_in);
    check(rdata, exp);
  endtask

  task automatic clr_acc();
    acc_clr = 1'b1;
    @(negedge sys_clk_in);
    acc_clr = 1'b0;
  endtask

  task automatic prog(input logic [7:0] val);
    u_host.write(`SCFC_ADDR_CTRL, val);
    u_host.write(`SCFC_ADDR_UPDATE, 8'h01);
    u_host.idle(4);
    n_exp++;
  endtask

  // A disabled or powered-down detector keeps its old flag.
  function automatic logic flag_exp(input logic [6:0] c, input logic [3:0] p, input logic old);
    if (!c[0] || c[4]) return old;
    return p >= (c[1] ? `SCFC_THR_NARROW : `SCFC_THR_WIDE);
  endfunction

  initial begin
    #100_000;
    fails++;
    summarize();
  end

  initial begin
    seed = 98;
    fails = 0;
    n_tests = 0;
    n_exp = 0;
    acc_clr = 1'b0;
    resetn_in = 1'b0;
    pin = `SCFC_PIN_IDLE;
    ign = 5'h00;
    phase = 4'h0;
    raddr = 8'h00;
    repeat (20) @(posedge sys_clk_in);
    @(negedge sys_clk_in);
    resetn_in = 1'b1;
    rd(`SCFC_ADDR_CTRL, 8'h00);
    check({dist_pd, sync_pd, oos, force_st}, 8'h00);
    u_host.write(`SCFC_ADDR_CTRL, 8'h08);
    u_host.idle(4);
    check({7'h00, dist_pd}, 8'h00);
    u_host.write(`SCFC_ADDR_UPDATE, 8'hff);
    u_host.idle(4);
    n_exp++;
    check({7'h00, dist_pd}, 8'h01);
    u_host.write(`SCFC_ADDR_CTRL, 8'h00);
    u_host.write(`SCFC_ADDR_UPDATE, 8'h01);
    u_host.write(`SCFC_ADDR_CTRL, 8'h10);
    prog(8'h10);
    n_exp++;
    check({6'h00, dist_pd, sync_pd}, 8'h01);
    u_host.write(`SCFC_ADDR_UNUSED, 8'hff);
    u_host.idle(2);
    rd(`SCFC_ADDR_UNUSED, 8'h00);
    rd(`SCFC_ADDR_UPDATE, 8'h00);
    prev = 7'h10;
    exp_oos = 1'b0;
    for (i = 0; i < 40; i++) begin
      v = 7'($random(seed));
      if (v[6:5] == 2'b10) v[6] = 1'b0;
      ign = 5'($random(seed));
      phase = 4'($random(seed) & 7);
      clr_acc();
      prog({1'b1, v});
      exp_oos = flag_exp(v, phase, flag_exp(prev, phase, exp_oos));
      rd(`SCFC_ADDR_CTRL, {1'b0, v});
      check({dist_pd, sync_pd, oos, force_st}, {v[3], v[4], exp_oos, v[2] ? ~ign : 5'h00});
      check({3'h0, trig_acc}, (prev[2] && !v[2]) ? {3'h0, ~ign} : 8'h00);
      prev = v;
    end
    ign = 5'h05;
    for (i = 0; i < 4; i++) begin
      if (i == 2) continue;
      prog({1'b0, i[1:0], 5'h00});
      clr_acc();
      pin = 1'b0;
      repeat (8) @(negedge sys_clk_in);
      check({chip_rst, pwr_dn, 1'b0, force_st}, {i == 0, i == 3, 1'b0, i == 1 ? ~ign : 5'h00});
      pin = 1'b1;
      repeat (8) @(negedge sys_clk_in);
      check({3'h0, trig_acc}, i == 1 ? {3'h0, ~ign} : 8'h00);
    end
    check(n_upd[7:0], n_exp[7:0]);
    summarize();
  end
endmodule
